// ### tec_prot_pkg.sv
package tec_prot_pkg;

   // clock rate in kHz, keeps cycle products inside 32 bits
   localparam int CLK_KHZ = 40000;

   // protection times as specified, in their own units
   localparam int T_CONFIRM_US = 100;
   localparam int T_HICCUP_MS = 15;
   localparam int T_DETECT_MS = 1;
   localparam int T_SD_WAIT_MS = 30;
   localparam int T_STRAP_MS = 20;
   localparam int T_SS_BASE_MS = 15;
   localparam int T_DISCH_MS = 1;

   // derived cycle counts (least times round up)
   localparam int CONFIRM_CYC = (T_CONFIRM_US * CLK_KHZ + 999) / 1000;
   localparam int HICCUP_CYC_DEF = T_HICCUP_MS * CLK_KHZ;
   localparam int DETECT_CYC_DEF = T_DETECT_MS * CLK_KHZ;
   localparam int SD_WAIT_CYC_DEF = T_SD_WAIT_MS * CLK_KHZ;
   localparam int STRAP_CYC_DEF = T_STRAP_MS * CLK_KHZ;
   localparam int SS_BASE_CYC_DEF = T_SS_BASE_MS * CLK_KHZ;
   localparam int DISCH_CYC_DEF = T_DISCH_MS * CLK_KHZ;

   // second ramp stage is 8/19 of the total ramp
   localparam logic [31:0] SS_SPLIT_NUM = 32'h0000_0008;
   localparam logic [31:0] SS_SPLIT_DEN = 32'h0000_0013;

   // register indices, byte address is four times the index
   localparam logic [3:0] REG_MAIN = 4'h0;
   localparam logic [3:0] REG_HEAT_I = 4'h1;
   localparam logic [3:0] REG_COOL_I = 4'h2;
   localparam logic [3:0] REG_HEAT_V = 4'h3;
   localparam logic [3:0] REG_COOL_V = 4'h4;
   localparam logic [3:0] REG_SEC = 4'h5;
   localparam logic [3:0] REG_LAST_RW = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'h9;
   localparam logic [3:0] REG_ID = 4'ha;

   // field positions
   localparam int MAIN_ON_BIT = 7;
   localparam int MAIN_SS_LSB = 2;
   localparam int MAIN_REFRESH_BIT = 1;
   localparam int LIMIT_EN_BIT = 7;

   // reset values: host on, slowest soft-start
   localparam logic [7:0] MAIN_RST = 8'h8c;
   localparam logic [7:0] OTHER_RST = 8'h00;
   // arbitrary identification value
   localparam logic [7:0] ID_VALUE = 8'h5a;

   // bus target addresses selected by the strap
   localparam logic [6:0] ADDR_FLOAT = 7'h60;
   localparam logic [6:0] ADDR_PULLED = 7'h21;

   typedef enum logic [3:0] {
      ST_OFF = 4'b0000,
      ST_DISCH = 4'b0001,
      ST_SS1 = 4'b0010,
      ST_SS2 = 4'b0011,
      ST_RUN = 4'b0100,
      ST_HICCUP = 4'b0101,
      ST_DETECT = 4'b0110,
      ST_OVP = 4'b0111,
      ST_OTP = 4'b1000
   } state_t;

   // asynchronous pin and comparator inputs
   typedef struct packed {
      logic en_pin;
      logic shutdown_pin;
      logic addr_strap_low;
      logic lin_lim1;
      logic lin_lim2;
      logic sw_overcurrent;
      logic v_secondary_over;
      logic vol_above_04;
      logic vos_above_04;
      logic vin_over;
      logic vin_below_55;
      logic overtemp;
      logic temp_warn;
      logic i_heat_over;
      logic i_cool_over;
      logic v_heat_over;
      logic v_cool_over;
      logic heating;
      logic cooling;
      logic short_seen;
   } cmp_t;

   // limit settings handed to the analog comparators
   typedef struct packed {
      logic heat_current_limit_en;
      logic [5:0] heat_current_limit_level;
      logic cool_current_limit_en;
      logic [5:0] cool_current_limit_level;
      logic heat_voltage_limit_en;
      logic [5:0] heat_voltage_limit_level;
      logic cool_voltage_limit_en;
      logic [5:0] cool_voltage_limit_level;
      logic [1:0] linear_leg_heat_secondary_limit;
      logic [1:0] linear_leg_cool_secondary_limit;
      logic [1:0] switching_leg_heat_limit;
      logic [1:0] switching_leg_cool_limit;
   } limit_cfg_t;

   // power stage controls
   typedef struct packed {
      logic stage_en;
      logic discharge_en;
      logic regulate_low;
      logic ramp_common;
      logic ramp_split;
      logic hold_linear;
      logic limit_override;
   } stage_ctl_t;

endpackage : tec_prot_pkg

// ### tec_driver_protection_control.sv
`timescale 1ns/1ps
// Overview of operation
// - first linear limit: hold linear, limit switching
// - second linear limit: stage off, hiccup
// - switching overcurrent confirmed over 100 us
// - six-bit first current limit levels
// - each limit acts only when enabled
// - exceeded limit overrides analog control input
// - four-level secondary limits, 2-bit fields
// - three faults start the hiccup sequence
// - hiccup 15 ms off, repeat if high
// - 1 ms detection then soft-start or hiccup
// - supply over-voltage off, restart below 5.5V
// - over-temperature shutdown with automatic recovery
// - nine registers always reachable over bus
// - strap picks target address 0x60 or 0x21
// - strap sampled after 20 ms from power-up
// - soft-start 15/30/60/120 ms, default 120
// - refresh bit clears flags, self-clears
// - stage on only with bit and pins high
// - live direction field 10, 01, 00
// - limit flags set on rise, sticky
// - power good in ramp stage two and normal operation
// - temperature flags latch until refresh
// - soft-start discharges until both below 0.4V
// - 30 ms wait after shutdown pin high
module tec_driver_protection_control
   import tec_prot_pkg::*;
#(
   parameter int HICCUP_CYC = HICCUP_CYC_DEF,
   parameter int DETECT_CYC = DETECT_CYC_DEF,
   parameter int SD_WAIT_CYC = SD_WAIT_CYC_DEF,
   parameter int STRAP_CYC = STRAP_CYC_DEF,
   parameter int SS_BASE_CYC = SS_BASE_CYC_DEF,
   parameter int DISCH_CYC = DISCH_CYC_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire cmp_t pins,
   output limit_cfg_t limit_cfg,
   output stage_ctl_t stage_ctl,
   output logic [6:0] target_addr
);

   // synchroniser stages and edge history
   cmp_t s1_q; // first stage, read only by s2_q
   cmp_t s2_q; // synchronised pins
   cmp_t prev_q; // previous synchronised value
   // register file
   logic [7:0] cfg_q [0:8]; // writable registers
   logic refresh_q; // one-cycle flag clear pulse
   // sticky status flags
   logic voltage_limit_seen_q;
   logic current_limit_seen_q;
   logic ot_q;
   logic otw_q;
   // sequencer
   state_t state_q;
   state_t state_d;
   logic [31:0] tmr_q; // time spent in current state
   logic tmr_clr; // restart timer, state unchanged
   logic [12:0] conf_q; // overcurrent confirmation count
   logic [31:0] sd_cnt_q; // time since shutdown pin high
   logic [31:0] strap_cnt_q; // time since power-up
   logic strap_done_q; // strap captured
   // bus outputs
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   stage_ctl_t stage_q;
   logic [6:0] target_addr_q;
   // decoded helpers
   logic [3:0] idx;
   logic addr_ok;
   logic wr_en;
   logic run_ok;
   logic powered;
   logic confirm_done;
   logic fault_now;
   logic cur_lim;
   logic volt_lim;
   logic [1:0] mode;
   logic pgood;
   logic [31:0] ss_tot;
   logic [31:0] ss_two;
   logic [31:0] ss_one;
   logic [7:0] status_val;
   // total ramp time for a soft-start selection
   function automatic logic [31:0] ss_total(input logic [1:0] sel, input logic [31:0] base);
      ss_total = base << sel;
   endfunction : ss_total
   // true once a timer reaches its count
   function automatic logic reached(input logic [31:0] t, input logic [31:0] lim);
      reached = (t + 32'h0000_0001) >= lim;
   endfunction : reached
   // two-flop synchroniser for all pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
         prev_q <= '0;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         prev_q <= s2_q;
      end
   end

   // address decode: word index, aligned, known register
   assign idx = paddr[5:2];
   always_comb begin
      if (paddr[7:6] != 2'b00 || paddr[1:0] != 2'b00) begin
         addr_ok = 1'b0; // outside the map
      end else if (idx <= REG_LAST_RW) begin
         addr_ok = 1'b1;
      end else if (idx == REG_STATUS || idx == REG_ID) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = 1'b0;
      end
   end

   // write takes effect at the access edge with pready high
   assign wr_en = psel && penable && pready_q && pwrite && addr_ok;
   // live status word
   assign status_val = {mode, voltage_limit_seen_q, current_limit_seen_q, pgood, 1'b0, ot_q, otw_q};
   // answer one cycle after setup: data, ready, error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel && !penable;
         pslverr_q <= psel && !penable && !addr_ok;
         if (psel && !penable) begin
            if (!addr_ok || pwrite) begin
               prdata_q <= 32'h0000_0000; // nothing to return
            end else if (idx == REG_STATUS) begin
               prdata_q <= {24'h00_0000, status_val};
            end else if (idx == REG_ID) begin
               prdata_q <= {24'h00_0000, ID_VALUE};
            end else begin
               prdata_q <= {24'h00_0000, cfg_q[idx]};
            end
         end
      end
   end

   // writable registers, reachable whatever the pins do
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i <= 8; i++) begin
            cfg_q[i] <= (i == 0) ? MAIN_RST : OTHER_RST;
         end
      end else if (wr_en && idx <= REG_LAST_RW) begin
         cfg_q[idx] <= pwdata[7:0];
         if (idx == REG_MAIN) begin
            cfg_q[0][MAIN_REFRESH_BIT] <= 1'b0;
         end
      end
   end

   // refresh pulse from a write of one to the refresh bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refresh_q <= 1'b0;
      end else begin
         refresh_q <= wr_en && idx == REG_MAIN && pwdata[MAIN_REFRESH_BIT];
      end
   end

   // limit settings straight from the registers
   assign limit_cfg.heat_current_limit_en = cfg_q[1][LIMIT_EN_BIT];
   assign limit_cfg.heat_current_limit_level = cfg_q[1][5:0];
   assign limit_cfg.cool_current_limit_en = cfg_q[2][LIMIT_EN_BIT];
   assign limit_cfg.cool_current_limit_level = cfg_q[2][5:0];
   assign limit_cfg.heat_voltage_limit_en = cfg_q[3][LIMIT_EN_BIT];
   assign limit_cfg.heat_voltage_limit_level = cfg_q[3][5:0];
   assign limit_cfg.cool_voltage_limit_en = cfg_q[4][LIMIT_EN_BIT];
   assign limit_cfg.cool_voltage_limit_level = cfg_q[4][5:0];
   assign limit_cfg.linear_leg_heat_secondary_limit = cfg_q[5][7:6];
   assign limit_cfg.linear_leg_cool_secondary_limit = cfg_q[5][5:4];
   assign limit_cfg.switching_leg_heat_limit = cfg_q[5][3:2];
   assign limit_cfg.switching_leg_cool_limit = cfg_q[5][1:0];

   // limit comparators gated by their enables
   assign cur_lim = (s2_q.i_heat_over && cfg_q[1][LIMIT_EN_BIT])
      || (s2_q.i_cool_over && cfg_q[2][LIMIT_EN_BIT]);
   assign volt_lim = (s2_q.v_heat_over && cfg_q[3][LIMIT_EN_BIT])
      || (s2_q.v_cool_over && cfg_q[4][LIMIT_EN_BIT]);
   // live direction: heating 10, cooling 01, boundary 00
   assign mode = {s2_q.heating && !s2_q.cooling, s2_q.cooling && !s2_q.heating};
   // power good only while ramp stage two or running
   assign pgood = (state_q == ST_SS2) || (state_q == ST_RUN);
   // sticky flags; a set in the refresh cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         voltage_limit_seen_q <= 1'b0;
         current_limit_seen_q <= 1'b0;
         ot_q <= 1'b0;
         otw_q <= 1'b0;
      end else begin
         voltage_limit_seen_q <= (voltage_limit_seen_q && !refresh_q) || (volt_lim && !prev_voltage_limit_seen());
         current_limit_seen_q <= (current_limit_seen_q && !refresh_q) || (cur_lim && !prev_current_limit_seen());
         ot_q <= (ot_q && !refresh_q) || s2_q.overtemp;
         otw_q <= (otw_q && !refresh_q) || s2_q.temp_warn;
      end
   end

   // previous gated voltage limit, for rise detection
   function automatic logic prev_voltage_limit_seen();
      prev_voltage_limit_seen = (prev_q.v_heat_over && cfg_q[3][LIMIT_EN_BIT])
         || (prev_q.v_cool_over && cfg_q[4][LIMIT_EN_BIT]);
   endfunction : prev_voltage_limit_seen
   // previous gated current limit, for rise detection
   function automatic logic prev_current_limit_seen();
      prev_current_limit_seen = (prev_q.i_heat_over && cfg_q[1][LIMIT_EN_BIT])
         || (prev_q.i_cool_over && cfg_q[2][LIMIT_EN_BIT]);
   endfunction : prev_current_limit_seen
   // delay after shutdown pin rises; restarts when it falls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sd_cnt_q <= 32'h0000_0000;
      end else if (!s2_q.shutdown_pin) begin
         sd_cnt_q <= 32'h0000_0000;
      end else if (sd_cnt_q != 32'(SD_WAIT_CYC)) begin
         sd_cnt_q <= sd_cnt_q + 32'h0000_0001;
      end
   end

   // all three enables must be high, pin delay served
   assign run_ok = cfg_q[0][MAIN_ON_BIT] && s2_q.en_pin
      && (sd_cnt_q == 32'(SD_WAIT_CYC));
   // strap capture once the power-up delay has passed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_cnt_q <= 32'h0000_0000;
         strap_done_q <= 1'b0;
         target_addr_q <= ADDR_FLOAT;
      end else if (!strap_done_q) begin
         strap_cnt_q <= strap_cnt_q + 32'h0000_0001;
         if (reached(strap_cnt_q, 32'(STRAP_CYC))) begin
            strap_done_q <= 1'b1;
            target_addr_q <= s2_q.addr_strap_low ? ADDR_PULLED : ADDR_FLOAT;
         end
      end
   end

   // stage is driving in these states
   assign powered = (state_q == ST_SS1) || (state_q == ST_SS2)
      || (state_q == ST_RUN) || (state_q == ST_DETECT);
   // switching-leg overcurrent must persist over the window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conf_q <= 13'h0000;
      end else if (!powered || !s2_q.sw_overcurrent) begin
         conf_q <= 13'h0000; // cleared in time: resume
      end else if (!confirm_done) begin
         conf_q <= conf_q + 13'h0001;
      end
   end
   assign confirm_done = s2_q.sw_overcurrent && (conf_q == 13'(CONFIRM_CYC - 1));
   // faults that start hiccup
   assign fault_now = s2_q.lin_lim2 || s2_q.v_secondary_over || confirm_done;
   // soft-start stage lengths
   assign ss_tot = ss_total(cfg_q[0][MAIN_SS_LSB +: 2], 32'(SS_BASE_CYC));
   assign ss_two = (ss_tot * SS_SPLIT_NUM) / SS_SPLIT_DEN;
   assign ss_one = ss_tot - ss_two;
   // next state of the protection sequencer
   always_comb begin
      state_d = state_q;
      tmr_clr = 1'b0;
      if (!run_ok) begin
         state_d = ST_OFF;
      end else if (s2_q.overtemp) begin
         state_d = ST_OTP;
      end else if (s2_q.vin_over) begin
         state_d = ST_OVP;
      end else begin
         case (state_q)
            ST_OFF: begin
               state_d = ST_DISCH; // start with a discharge
            end
            ST_OTP: begin
               state_d = ST_DISCH;
            end
            ST_OVP: begin
               if (s2_q.vin_below_55) begin
                  state_d = ST_DISCH;
               end
            end
            ST_DISCH: begin
               if (reached(tmr_q, 32'(DISCH_CYC))) begin
                  if (!s2_q.vol_above_04 && !s2_q.vos_above_04) begin
                     state_d = ST_SS1;
                  end else begin
                     tmr_clr = 1'b1;
                  end
               end
            end
            ST_SS1: begin
               if (fault_now) begin
                  state_d = ST_HICCUP;
               end else if (reached(tmr_q, ss_one)) begin
                  state_d = ST_SS2;
               end
            end
            ST_SS2: begin
               if (fault_now) begin
                  state_d = ST_HICCUP;
               end else if (reached(tmr_q, ss_two)) begin
                  state_d = ST_RUN;
               end
            end
            ST_RUN: begin
               if (fault_now) begin
                  state_d = ST_HICCUP;
               end
            end
            ST_HICCUP: begin
               if (reached(tmr_q, 32'(HICCUP_CYC))) begin
                  if (s2_q.vol_above_04 || s2_q.vos_above_04) begin
                     tmr_clr = 1'b1;
                  end else begin
                     state_d = ST_DETECT;
                  end
               end
            end
            ST_DETECT: begin
               if (fault_now || s2_q.short_seen) begin
                  state_d = ST_HICCUP;
               end else if (reached(tmr_q, 32'(DETECT_CYC))) begin
                  state_d = ST_DISCH;
               end
            end
            default: begin
               state_d = ST_OFF;
            end
         endcase
      end
   end

   // sequencer state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // one timer for every sequencer state interval, cleared on each state change and on tmr_clr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr_q <= 32'h0000_0000;
      end else if (state_d != state_q || tmr_clr) begin
         tmr_q <= 32'h0000_0000;
      end else begin
         tmr_q <= tmr_q + 32'h0000_0001;
      end
   end

   // power stage controls registered from the next state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_q <= '0;
      end else begin
         stage_q.stage_en <= (state_d == ST_SS1) || (state_d == ST_SS2)
            || (state_d == ST_RUN) || (state_d == ST_DETECT);
         stage_q.discharge_en <= (state_d == ST_OFF) || (state_d == ST_DISCH)
            || (state_d == ST_HICCUP) || (state_d == ST_OVP);
         stage_q.regulate_low <= state_d == ST_DETECT;
         stage_q.ramp_common <= state_d == ST_SS1;
         stage_q.ramp_split <= state_d == ST_SS2;
         stage_q.hold_linear <= s2_q.lin_lim1 && (state_d == ST_RUN || state_d == ST_SS2);
         stage_q.limit_override <= (cur_lim || volt_lim || s2_q.lin_lim1)
            && (state_d == ST_RUN || state_d == ST_SS2);
      end
   end

   // outputs straight from flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign stage_ctl = stage_q;
   assign target_addr = target_addr_q;
endmodule : tec_driver_protection_control

// ### tec_prot_properties.sv
`timescale 1ns/1ps
// protocol and sequencing checks on the top-level ports
module tec_prot_properties
   import tec_prot_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire cmp_t pins,
   input wire limit_cfg_t limit_cfg,
   input wire stage_ctl_t stage_ctl,
   input wire logic [6:0] target_addr
);
   // run length of the switching overcurrent input
   logic [12:0] sw_cnt_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_cnt_q <= 13'h0000;
      end else begin
         sw_cnt_q <= pins.sw_overcurrent ? sw_cnt_q + 13'h0001 : 13'h0000;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_err; psel && !penable && (paddr > 8'h28 || paddr[1:0] != 2'b00)
      |=> pready && pslverr; endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
   property p_en; !pins.en_pin [*5] |-> !stage_ctl.stage_en; endproperty
   a_en: assert property (p_en) else $error("stage on with enable low");
   property p_sd; $rose(pins.shutdown_pin) |-> !stage_ctl.stage_en [*8]; endproperty
   a_sd: assert property (p_sd) else $error("stage on too soon");
   property p_ovp; pins.vin_over [*5] |-> !stage_ctl.stage_en; endproperty
   a_ovp: assert property (p_ovp) else $error("stage on in over-voltage");
   property p_otp; pins.overtemp [*5] |-> !stage_ctl.stage_en; endproperty
   a_otp: assert property (p_otp) else $error("stage on in over-temperature");
   property p_lin2; $rose(pins.lin_lim2) && stage_ctl.stage_en
      |-> ##[1:5] !stage_ctl.stage_en; endproperty
   a_lin2: assert property (p_lin2) else $error("second limit left stage on");
   property p_swlong; sw_cnt_q == 13'h0fba |-> !stage_ctl.stage_en; endproperty
   a_swlong: assert property (p_swlong) else $error("overcurrent not confirmed");
   property p_swshort; $rose(pins.sw_overcurrent) && stage_ctl.stage_en
      |=> stage_ctl.stage_en [*8]; endproperty
   a_swshort: assert property (p_swshort) else $error("overcurrent acted early");
   property p_lim; psel && penable && pready && pwrite && paddr == 8'h04
      |=> {limit_cfg.heat_current_limit_en, limit_cfg.heat_current_limit_level}
      == {$past(pwdata[7]), $past(pwdata[5:0])}; endproperty
   a_lim: assert property (p_lim) else $error("heat limit not applied");
   property p_sec; psel && penable && pready && pwrite && paddr == 8'h14
      |=> {limit_cfg.linear_leg_heat_secondary_limit, limit_cfg.linear_leg_cool_secondary_limit,
      limit_cfg.switching_leg_heat_limit, limit_cfg.switching_leg_cool_limit}
      == $past(pwdata[7:0]); endproperty
   a_sec: assert property (p_sec) else $error("secondary limits not applied");
endmodule : tec_prot_properties
bind tec_driver_protection_control tec_prot_properties u_props (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
   .limit_cfg(limit_cfg), .stage_ctl(stage_ctl), .target_addr(target_addr));

// ### power_stage_model.sv
`timescale 1ns/1ps
// analog side: comparator levels seen by the sequencer
module power_stage_model
   import tec_prot_pkg::*;
(
   input wire logic pclk,
   input wire stage_ctl_t stage_ctl,
   input wire cmp_t cmd,
   input wire logic stuck,
   output cmp_t pins
);
   // outputs charged while the stage drives above the low level
   logic hi_q;
   always_ff @(posedge pclk) begin
      hi_q <= stage_ctl.stage_en && !stage_ctl.regulate_low;
   end
   // a stuck terminal keeps both comparators high
   always_comb begin
      pins = cmd;
      pins.vol_above_04 = hi_q || stuck;
      pins.vos_above_04 = hi_q || stuck;
   end
endmodule : power_stage_model

// ### tec_driver_protection_control_test.sv
`timescale 1ns/1ps
module tec_driver_protection_control_test import tec_prot_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stuck, e;
   logic [7:0] paddr, r;
   logic [31:0] pwdata, prdata;
   logic [1:0] hc2;
   logic [6:0] target_addr;
   cmp_t cmd, pins;
   limit_cfg_t limit_cfg;
   stage_ctl_t stage_ctl;
   int error_cnt = 0;
   int n_compared = 0;
   // fault rows: toggled pins, hold cycles, expected status
   logic [19:0] hm [9] = '{20'h08000, 20'h02000, 20'h04000, 20'h04000, 20'h00400,
      20'h00100, 20'h08000, 20'h80000, 20'h40000};
   int hn [9] = '{20, 20, 100, 4060, 20, 20, 150, 20, 20};
   logic [7:0] hx [9] = '{8'h80, 8'h80, 8'h88, 8'h80, 8'h80, 8'h82, 8'h80, 8'h80, 8'h80};
   logic [8:0] h_on = 9'h004;
   logic [8:0] h_skip = 9'h008;
   logic [8:0] h_stuck = 9'h040;
   tec_driver_protection_control #(.HICCUP_CYC(50), .DETECT_CYC(20), .SD_WAIT_CYC(30),
      .STRAP_CYC(40), .SS_BASE_CYC(38), .DISCH_CYC(10)) u_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
      .limit_cfg(limit_cfg), .stage_ctl(stage_ctl), .target_addr(target_addr));
   power_stage_model u_stage (.pclk(pclk), .stage_ctl(stage_ctl), .cmd(cmd),
      .stuck(stuck), .pins(pins));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer, held until pready
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task wait_pg;
      int k;
      k = 0;
      do begin
         apb(1'b0, 8'h24, 8'h00);
         k++;
      end while (r[3] !== 1'b1 && k < 200);
      chk(r, 8'h88);
   endtask : wait_pg
   // apply one fault row, then refresh and wait for recovery
   task hit(input int j);
      int on;
      on = 0;
      cmd <= cmd ^ hm[j];
      stuck <= h_stuck[j];
      for (int k = 0; k < hn[j]; k++) begin
         @(posedge pclk);
         if (k > 8 && stage_ctl.stage_en === 1'b1) on++;
      end
      if (!h_on[j] && !h_skip[j]) chk(8'(on), 8'h00);
      if (h_on[j]) chk({7'h00, stage_ctl.stage_en}, 8'h01);
      apb(1'b0, 8'h24, 8'h00);
      chk(r, hx[j]);
      cmd <= cmd ^ hm[j];
      stuck <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b1, 8'h00, 8'h82);
      wait_pg();
      $display("fault case %0d done", j);
   endtask : hit
   task report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (40000) @(posedge pclk);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      stuck = 1'b0;
      cmd = 20'he0204;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({1'b0, target_addr}, 8'h60);
      apb(1'b0, 8'h00, 8'h00);
      chk(r, 8'h8c);
      apb(1'b0, 8'h28, 8'h00);
      chk(r, 8'h5a);
      apb(1'b0, 8'h2c, 8'h00);
      chk({7'h00, e}, 8'h01);
      apb(1'b0, 8'h01, 8'h00);
      chk({7'h00, e}, 8'h01);
      for (int i = 1; i < 9; i++) begin
         apb(1'b1, 8'(4 * i), 8'(i + 1));
         apb(1'b0, 8'(4 * i), 8'h00);
         chk(r, 8'(i + 1));
      end
      chk({1'b0, target_addr}, 8'h21);
      $display("registers done");
      apb(1'b1, 8'h00, 8'h80);
      wait_pg();
      $display("start-up done");
      for (int j = 0; j < 3; j++) begin
         hc2 = (j == 0) ? 2'b10 : (j == 1) ? 2'b01 : 2'b11;
         {cmd.heating, cmd.cooling} <= hc2;
         repeat (4) @(posedge pclk);
         apb(1'b0, 8'h24, 8'h00);
         chk(r, {(hc2 == 2'b11) ? 2'b00 : hc2, 6'h08});
      end
      {cmd.heating, cmd.cooling} <= 2'b10;
      $display("direction done");
      apb(1'b1, 8'h04, 8'hbf);
      // heat and cool limits, warning, first linear limit; only the heat current limit is enabled
      cmd <= cmd ^ 20'h100f8;
      repeat (6) @(posedge pclk);
      chk({6'h00, stage_ctl.hold_linear, stage_ctl.limit_override}, 8'h03);
      cmd <= cmd ^ 20'h100f8;
      repeat (6) @(posedge pclk);
      chk({6'h00, stage_ctl.hold_linear, stage_ctl.limit_override}, 8'h00);
      apb(1'b0, 8'h24, 8'h00);
      chk(r, 8'h99);
      apb(1'b1, 8'h00, 8'h82);
      apb(1'b0, 8'h00, 8'h00);
      chk(r, 8'h80);
      apb(1'b0, 8'h24, 8'h00);
      chk(r, 8'h88);
      $display("flags done");
      for (int j = 0; j < 9; j++) begin
         hit(j);
      end
      apb(1'b1, 8'h00, 8'h00);
      repeat (5) @(posedge pclk);
      apb(1'b0, 8'h24, 8'h00);
      chk(r, 8'h80);
      apb(1'b1, 8'h00, 8'h80);
      wait_pg();
      $display("host switch done");
      report_and_stop();
   end
endmodule : tec_driver_protection_control_test
